// file: logic/rss_pkg.sv
// constants, field layouts and carrier types for the runtime status slice
// assumes: one 250 MHz clock, classic wishbone with 32-bit data
package rss_pkg;

	// ------------------------------------------------------------
	// register indices; byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_IRQ_EN5   = 6'h1a;
	localparam logic [5:0] IDX_RSVD_A    = 6'h1b;
	localparam logic [5:0] IDX_EDGE_STS  = 6'h1c;
	localparam logic [5:0] IDX_RSVD_B    = 6'h1d;
	localparam logic [5:0] IDX_FORCE_CHG = 6'h1e;
	localparam logic [5:0] IDX_RATE_MIR  = 6'h1f;
	localparam logic [5:0] IDX_SER1_MIR  = 6'h20;
	localparam logic [5:0] IDX_SER2_MIR  = 6'h21;

	// ------------------------------------------------------------
	// reset values and field masks
	// ------------------------------------------------------------
	localparam logic [7:0] IRQ_EN5_RST   = 8'h00;
	localparam logic [7:0] EDGE_STS_RST  = 8'h00;
	localparam logic [1:0] FORCE_CHG_RST = 2'h3;
	localparam logic [7:0] IRQ_EN5_MASK  = 8'hcf;
	localparam logic [7:0] EDGE_STS_MASK = 8'h3f;
	localparam logic [7:0] RATE_MASK     = 8'hdf;
	localparam logic [7:0] FIFO_MASK     = 8'hcf;

	// ------------------------------------------------------------
	// field positions and widths
	// ------------------------------------------------------------
	localparam int FAN1_BIT     = 6;
	localparam int FAN2_BIT     = 7;
	localparam int EDGE_BITS    = 6;
	localparam int PIN_BITS     = 16;
	localparam int DISK_CHG_BIT = 7;

	// pins straight from the package balls, asynchronous to clk_i
	typedef struct packed {
		logic       fan_speed_input_2;
		logic       fan_speed_input_1;
		logic       pin_57;
		logic       pin_56;
		logic       pin_55;
		logic       pin_54;
		logic       pin_61;
		logic       pin_60;
		logic       pin_43;
		logic       pin_41;
		logic       pin_22;
		logic       pin_21;
		logic       step_pulse;
		logic       drive_select_0;
		logic       drive_select_1;
		logic       media_changed_in;
	} rss_pins_t;

	// live copies of the floppy and serial control registers
	typedef struct packed {
		logic [7:0] floppy_rate;
		logic [7:0] serial1_fcr;
		logic [7:0] serial2_fcr;
	} rss_shadow_t;

endpackage

// file: logic/rss_regs.sv
// register slice: irq enable five, edge status, forced media change, mirrors
// assumes: wishbone master on clk_i, pins asynchronous, mirrors on clk_i
//
// Contract
// - enabled sources drive group management interrupt
// - reserved locations 1b and 1d read zero
// - writing one clears edge status bit
// - either edge on pins sets status
// - status bits seven and six read zero
// - enable and status reset to zero
// - force change set only, resets to three
// - step or drive select clears force change
// - disk change ORs forced and external terms
// - floppy rate mirror readable at 1f
// - serial one fifo mirror at 20
// - serial two fifo mirror at 21
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/100ps

module rss_regs
	import rss_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        main_por_i,
	input  wire logic        bus_reset_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire rss_pins_t   pins_i,
	input  wire rss_shadow_t shadow_i,
	output logic             group_mgmt_irq_o,
	output logic             disk_change_status_o
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	rss_pins_t sync1_r;
	rss_pins_t sync2_r;
	rss_pins_t prev_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r  <= '0;
		end else begin
			sync1_r <= pins_i;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	logic [EDGE_BITS-1:0] edge_lvl;
	logic [EDGE_BITS-1:0] edge_old;
	logic [EDGE_BITS-1:0] edge_hit;
	logic [7:0]           irq_src;

	always_comb begin
		edge_lvl = {sync2_r.pin_61, sync2_r.pin_60, sync2_r.pin_43,
		            sync2_r.pin_41, sync2_r.pin_22, sync2_r.pin_21};
		edge_old = {prev_r.pin_61, prev_r.pin_60, prev_r.pin_43,
		            prev_r.pin_41, prev_r.pin_22, prev_r.pin_21};
		edge_hit = edge_lvl ^ edge_old;
		irq_src  = {sync2_r.fan_speed_input_2, sync2_r.fan_speed_input_1, 2'b00,
		            sync2_r.pin_57, sync2_r.pin_56, sync2_r.pin_55, sync2_r.pin_54};
	end

	// ------------------------------------------------------------
	// wishbone decode
	// ------------------------------------------------------------
	logic [5:0] idx;
	logic       req;
	logic       wr_lo;
	logic       rd;

	always_comb begin
		idx   = adr_i[7:2];
		req   = cyc_i && stb_i && !ack_o;
		wr_lo = req && we_i && sel_i[0];
		rd    = req && !we_i;
	end

	logic wr_en5;
	logic wr_sts;
	logic wr_fc;

	always_comb begin
		wr_en5 = wr_lo && (idx == IDX_IRQ_EN5);
		wr_sts = wr_lo && (idx == IDX_EDGE_STS);
		wr_fc  = wr_lo && (idx == IDX_FORCE_CHG);
	end

	// ------------------------------------------------------------
	// irq enable five
	// ------------------------------------------------------------
	logic [7:0] irq_en_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_en_r <= IRQ_EN5_RST;
		end else if (wr_en5) begin
			irq_en_r <= dat_i[7:0] & IRQ_EN5_MASK;
		end
	end

	// ------------------------------------------------------------
	// edge status, write one to clear
	// ------------------------------------------------------------
	logic [7:0] sts_r;
	logic [7:0] sts_nxt;

	always_comb begin
		sts_nxt = sts_r;
		if (wr_sts) begin
			sts_nxt = sts_nxt & ~dat_i[7:0];
		end
		// an edge landing with the clear still counts
		sts_nxt = (sts_nxt | {2'b00, edge_hit}) & EDGE_STS_MASK;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sts_r <= EDGE_STS_RST;
		end else begin
			sts_r <= sts_nxt;
		end
	end

	// ------------------------------------------------------------
	// forced media change
	// ------------------------------------------------------------
	logic [1:0] fc_r;
	logic [1:0] fc_nxt;
	logic [1:0] fc_clr;

	always_comb begin
		fc_clr[0] = sync2_r.step_pulse || sync2_r.drive_select_0;
		fc_clr[1] = sync2_r.step_pulse || sync2_r.drive_select_1;
		fc_nxt    = fc_r & ~fc_clr;
		// software set wins over a drive clear in the same cycle
		if (wr_fc) begin
			fc_nxt = fc_nxt | dat_i[1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || main_por_i || bus_reset_i) begin
			fc_r <= FORCE_CHG_RST;
		end else begin
			fc_r <= fc_nxt;
		end
	end

	// ------------------------------------------------------------
	// mirrors of floppy rate and serial fifo control
	// ------------------------------------------------------------
	rss_shadow_t mir_r;

	// no write path reaches the mirrors
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mir_r <= '0;
		end else begin
			mir_r.floppy_rate <= shadow_i.floppy_rate & RATE_MASK;
			mir_r.serial1_fcr <= shadow_i.serial1_fcr & FIFO_MASK;
			mir_r.serial2_fcr <= shadow_i.serial2_fcr & FIFO_MASK;
		end
	end

	// ------------------------------------------------------------
	// read mux and acknowledge
	// ------------------------------------------------------------
	logic [7:0] rd_byte;

	always_comb begin
		unique case (idx)
			IDX_IRQ_EN5:   rd_byte = irq_en_r;
			IDX_EDGE_STS:  rd_byte = sts_r;
			IDX_FORCE_CHG: rd_byte = {6'h00, fc_r};
			IDX_RATE_MIR:  rd_byte = mir_r.floppy_rate;
			IDX_SER1_MIR:  rd_byte = mir_r.serial1_fcr;
			IDX_SER2_MIR:  rd_byte = mir_r.serial2_fcr;
			IDX_RSVD_A:    rd_byte = 8'h00;
			IDX_RSVD_B:    rd_byte = 8'h00;
			default:       rd_byte = 8'h00;
		endcase
	end

	// unmapped and reserved writes are acked and dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (rd) begin
			dat_o <= {24'h00_0000, rd_byte};
		end
	end

	// ------------------------------------------------------------
	// interrupt and disk change outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			group_mgmt_irq_o <= 1'b0;
		end else begin
			group_mgmt_irq_o <= |(irq_en_r & irq_src);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			disk_change_status_o <= 1'b0;
		end else begin
			disk_change_status_o <= (sync2_r.drive_select_0 && fc_r[0]) ||
			                        (sync2_r.drive_select_1 && fc_r[1]) ||
			                        sync2_r.media_changed_in;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	irq_route_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(|(irq_en_r & irq_src)) |=> group_mgmt_irq_o)
		else $error("enabled source did not raise interrupt");

	irq_quiet_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(irq_en_r == 8'h00) ##1 (irq_en_r == 8'h00) |-> !group_mgmt_irq_o)
		else $error("interrupt raised with all sources disabled");

	rsvd_read_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		rd && (idx == IDX_RSVD_A || idx == IDX_RSVD_B) |=> ack_o && dat_o == 32'h0)
		else $error("reserved location read nonzero");

	w1c_clear_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_sts && (edge_hit == 6'h00) |=> (sts_r & $past(dat_i[7:0])) == 8'h00)
		else $error("written one did not clear status");

	w0_keep_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_sts |=> (sts_r & ~$past(dat_i[7:0])) == (($past(sts_r) | {2'b00,
			$past(edge_hit)}) & ~$past(dat_i[7:0])))
		else $error("written zero changed status");

	edge_set_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$changed(sync2_r.pin_21) |=> sts_r[0])
		else $error("edge on pin 21 not recorded");

	edge_last_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$changed(sync2_r.pin_61) |=> sts_r[5])
		else $error("edge on pin 61 not recorded");

	sts_top_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		rd && (idx == IDX_EDGE_STS) |=> dat_o[7:6] == 2'b00)
		else $error("status upper bits not zero");

	reset_val_a: assert property (
		@(posedge clk_i)
		$past(rst_i) |-> irq_en_r == IRQ_EN5_RST && sts_r == EDGE_STS_RST &&
			fc_r == FORCE_CHG_RST)
		else $error("wrong value after reset");

	fc_noclear_a: assert property (
		@(posedge clk_i) disable iff (rst_i || main_por_i || bus_reset_i)
		wr_fc && dat_i[0] |=> fc_r[0])
		else $error("force change set was lost");

	fc_por_a: assert property (
		@(posedge clk_i)
		main_por_i || bus_reset_i |=> fc_r == FORCE_CHG_RST)
		else $error("force change not preset by reset");

	fc_drive_a: assert property (
		@(posedge clk_i) disable iff (rst_i || main_por_i || bus_reset_i)
		sync2_r.step_pulse && !wr_fc |=> fc_r == 2'b00)
		else $error("step did not clear force change");

	fc_ds1_clr_a: assert property (
		@(posedge clk_i) disable iff (rst_i || main_por_i || bus_reset_i)
		sync2_r.drive_select_1 && !wr_fc |=> !fc_r[1])
		else $error("drive one select did not clear force change");

	fc_keep_a: assert property (
		@(posedge clk_i) disable iff (rst_i || main_por_i || bus_reset_i)
		wr_fc && !dat_i[1] && fc_r[1] && !sync2_r.step_pulse &&
			!sync2_r.drive_select_1 |=> fc_r[1])
		else $error("software write cleared force change");

	disk_drv1_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sync2_r.drive_select_1 && fc_r[1] |=> disk_change_status_o)
		else $error("forced change not shown for drive one");

	disk_drv0_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sync2_r.drive_select_0 && fc_r[0] |=> disk_change_status_o)
		else $error("forced change not shown for drive zero");

	disk_idle_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!sync2_r.media_changed_in && !(sync2_r.drive_select_0 && fc_r[0]) &&
			!(sync2_r.drive_select_1 && fc_r[1]) |=> !disk_change_status_o)
		else $error("disk change raised with no term active");

	mirror_rd_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		rd && (idx == IDX_RATE_MIR) |=> dat_o[7:0] == $past(mir_r.floppy_rate) &&
			dat_o[5] == 1'b0)
		else $error("rate mirror read wrong");

	ser1_rd_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		rd && (idx == IDX_SER1_MIR) |=> dat_o[7:0] == $past(mir_r.serial1_fcr))
		else $error("serial one mirror read wrong");

	ser2_rd_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		rd && (idx == IDX_SER2_MIR) |=> dat_o[7:0] == $past(mir_r.serial2_fcr) &&
			dat_o[5:4] == 2'b00)
		else $error("serial two mirror read wrong");

	ro_write_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_lo && idx >= IDX_RATE_MIR |=> $stable(irq_en_r) && ack_o)
		else $error("write to mirror disturbed state");

endmodule

// file: testbench/tb_top.sv
// directed bench for the runtime status slice over classic wishbone
// assumes: rss_regs as listed, pins active high, byte address 4 * index
`timescale 1ns/100ps

module tb_top
	import rss_pkg::*;
;
	logic        clk_i;
	logic        rst_i;
	logic        main_por_i;
	logic        bus_reset_i;
	logic        cyc_i;
	logic        stb_i;
	logic        we_i;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic        ack_o;
	rss_pins_t   pins;
	rss_shadow_t shadow;
	logic        group_mgmt_irq_o;
	logic        disk_change_status_o;
	int          err_total;
	int          samples_checked;

	rss_regs u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .main_por_i(main_por_i), .bus_reset_i(bus_reset_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pins_i(pins), .shadow_i(shadow),
		.group_mgmt_irq_o(group_mgmt_irq_o), .disk_change_status_o(disk_change_status_o)
	);

	always #2 clk_i = ~clk_i;

	// ------------------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic bad(input string msg);
		err_total++;
		$display("BAD t=%0t %s", $time, msg);
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		n = 0;
		// ack and data are read as they stood at the edge
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		if (n >= 20) begin
			bad("bus timeout");
			test_done();
		end
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, {24'h0, d}, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		samples_checked++;
		if (q !== {24'h0, exp}) begin
			bad($sformatf("read %h got %h want %h", a, q, exp));
		end
	endtask

	// waits up to 20 cycles for an output level; dsk picks disk change
	task automatic wait_out(input logic dsk, input logic v);
		int n;
		logic s;
		n = 0;
		do begin
			@(posedge clk_i);
			s = dsk ? disk_change_status_o : group_mgmt_irq_o;
			n++;
		end while (s !== v && n < 20);
		samples_checked++;
		if (s !== v) begin
			bad($sformatf("output %0d not at %b", dsk, v));
		end
	endtask

	task automatic pin(input int idx, input logic v);
		@(posedge clk_i);
		pins[idx] <= v;
		repeat (8) @(posedge clk_i);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		main_por_i = 1'b0;
		bus_reset_i = 1'b0;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h00;
		sel_i = 4'h0;
		dat_i = 32'h0;
		pins = '0;
		shadow = '{floppy_rate: 8'hff, serial1_fcr: 8'hff, serial2_fcr: 8'h5a};
		err_total = 0;
		samples_checked = 0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(8'h68, 8'h00);
		rd(8'h70, 8'h00);
		rd(8'h78, 8'h03);
		wr(8'h6c, 8'hff);
		wr(8'h74, 8'hff);
		rd(8'h6c, 8'h00);
		rd(8'h74, 8'h00);
		rd(8'h68, 8'h00);
		rd(8'h70, 8'h00);
		rd(8'h78, 8'h03);
		rd(8'hfc, 8'h00);
		wr(8'h68, 8'hff);
		rd(8'h68, 8'hcf);
		wr(8'h68, 8'h00);
		// each source alone, first held off by its clear enable bit
		for (int i = 0; i < 8; i++) begin
			if (i == 4 || i == 5) continue;
			pin(i < 4 ? 10 + i : 8 + i, 1'b1);
			wait_out(1'b0, 1'b0);
			wr(8'h68, 8'h01 << i);
			wait_out(1'b0, 1'b1);
			wr(8'h68, 8'h00);
			wait_out(1'b0, 1'b0);
			pin(i < 4 ? 10 + i : 8 + i, 1'b0);
		end
		// rising edges one pin at a time, then falling edges
		for (int i = 0; i < 6; i++) begin
			pin(4 + i, 1'b1);
			rd(8'h70, (8'h02 << i) - 8'h01);
		end
		wr(8'h70, 8'h15);
		rd(8'h70, 8'h2a);
		wr(8'h70, 8'hff);
		rd(8'h70, 8'h00);
		for (int i = 0; i < 6; i++) begin
			pin(4 + i, 1'b0);
			rd(8'h70, 8'h01 << i);
			wr(8'h70, 8'h01 << i);
		end
		rd(8'h70, 8'h00);
		// forced media change and its clearing terms
		pin(2, 1'b1);
		pin(2, 1'b0);
		rd(8'h78, 8'h02);
		wr(8'h78, 8'h00);
		rd(8'h78, 8'h02);
		pin(1, 1'b1);
		pin(1, 1'b0);
		rd(8'h78, 8'h00);
		wr(8'h78, 8'h01);
		rd(8'h78, 8'h01);
		wr(8'h78, 8'h03);
		pin(3, 1'b1);
		pin(3, 1'b0);
		rd(8'h78, 8'h00);
		@(posedge clk_i);
		main_por_i <= 1'b1;
		@(posedge clk_i);
		main_por_i <= 1'b0;
		rd(8'h78, 8'h03);
		pin(3, 1'b1);
		pin(3, 1'b0);
		@(posedge clk_i);
		bus_reset_i <= 1'b1;
		@(posedge clk_i);
		bus_reset_i <= 1'b0;
		rd(8'h78, 8'h03);
		wait_out(1'b1, 1'b0);
		pin(0, 1'b1);
		wait_out(1'b1, 1'b1);
		pin(0, 1'b0);
		wait_out(1'b1, 1'b0);
		// selecting a forced drive shows disk change until its clear lands
		@(posedge clk_i);
		pins[2] <= 1'b1;
		wait_out(1'b1, 1'b1);
		pin(2, 1'b0);
		wait_out(1'b1, 1'b0);
		rd(8'h78, 8'h02);
		// mirrors hide reserved bits and ignore writes
		rd(8'h7c, 8'hdf);
		rd(8'h80, 8'hcf);
		rd(8'h84, 8'h4a);
		wr(8'h7c, 8'hff);
		wr(8'h80, 8'hff);
		wr(8'h84, 8'hff);
		rd(8'h68, 8'h00);
		rd(8'h78, 8'h02);
		rd(8'h7c, 8'hdf);
		rd(8'h84, 8'h4a);
		@(posedge clk_i);
		shadow <= '{floppy_rate: 8'h20, serial1_fcr: 8'h3a, serial2_fcr: 8'hc1};
		repeat (3) @(posedge clk_i);
		rd(8'h7c, 8'h00);
		rd(8'h80, 8'h0a);
		rd(8'h84, 8'hc1);
		test_done();
	end
endmodule
